// ---- io_bus_if.sv ----
`timescale 1ns/1ps

interface io_bus_if;
    logic [3:0] io_addr;
    logic [7:0] io_wdata;
    logic       io_wr;
    logic       io_rd;
    logic [7:0] io_rdata;

    modport dev (
        input  io_addr,
        input  io_wdata,
        input  io_wr,
        input  io_rd,
        output io_rdata
    );

    modport cpu (
        output io_addr,
        output io_wdata,
        output io_wr,
        output io_rd,
        input  io_rdata
    );
endinterface

// ---- oc_bus_sva.sv ----
`timescale 1ns/1ps
`include "oc_consts.svh"

module oc_bus_sva (
    input wire logic       clock,
    input wire logic       sys_rst,
    input wire logic [3:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic       io_wr,
    input wire logic       io_rd,
    input wire logic [7:0] io_rdata
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    one_strobe_a: assert property (!(io_wr && io_rd))
        else $error("write and read strobe together");
    high_then_low_a: assert property (io_wr && (io_addr == `OC_ADDR_CMPA_H || io_addr == `OC_ADDR_CMPB_H)
        |=> io_wr && io_addr == $past(io_addr) - 4'h1)
        else $error("high byte not followed by low byte");
    low_after_high_a: assert property (io_wr && (io_addr == `OC_ADDR_CMPA_L || io_addr == `OC_ADDR_CMPB_L)
        |-> $past(io_wr) && $past(io_addr) == io_addr + 4'h1)
        else $error("low byte written without high byte");
    read_pair_a: assert property (io_rd && (io_addr == `OC_ADDR_CMPA_L || io_addr == `OC_ADDR_CMPB_L)
        |=> io_rd && io_addr == $past(io_addr) + 4'h1)
        else $error("word read not low then high");
    rdata_hold_a: assert property (!$past(io_rd) |-> $stable(io_rdata))
        else $error("read data moved without a read");
    force_reads_zero_a: assert property ($past(io_rd) && $past(io_addr) == `OC_ADDR_FORCE |-> io_rdata == 8'h00)
        else $error("force location read not zero");
    unmapped_zero_a: assert property ($past(io_rd) && $past(io_addr) > `OC_ADDR_FLAGS |-> io_rdata == 8'h00)
        else $error("unmapped read not zero");
    flags_width_a: assert property ($past(io_rd) && $past(io_addr) == `OC_ADDR_FLAGS |-> io_rdata[7:2] == 6'h00)
        else $error("flag byte has stray bits");
endmodule

// ---- oc_consts.svh ----
`ifndef OC_CONSTS_SVH
`define OC_CONSTS_SVH

// Device I/O map, one byte per location
`define OC_ADDR_CMPA_L   4'h0
`define OC_ADDR_CMPA_H   4'h1
`define OC_ADDR_CMPB_L   4'h2
`define OC_ADDR_CMPB_H   4'h3
`define OC_ADDR_ACTION   4'h4
`define OC_ADDR_MODE     4'h5
`define OC_ADDR_FORCE    4'h6
`define OC_ADDR_IRQ_EN   4'h7
`define OC_ADDR_FLAGS    4'h8

// Field positions in the action byte
`define OC_ACT_A_LSB     0
`define OC_ACT_B_LSB     2

// Compare output actions
`define OC_ACT_NONE      2'h0
`define OC_ACT_TOGGLE    2'h1
`define OC_ACT_CLEAR     2'h2
`define OC_ACT_SET       2'h3

// Waveform modes
`define OC_MODE_NORMAL   4'h0
`define OC_MODE_PC_A     4'hB
`define OC_MODE_PFC_ICR  4'h8
`define OC_MODE_PFC_A    4'h9
`define OC_MODE_CTC_A    4'h4
`define OC_MODE_CTC_ICR  4'hC
`define OC_MODE_FAST_A   4'hF
`define OC_MODE_RESERVED 4'hD

// Reset values
`define OC_RST_BYTE      8'h00
`define OC_RST_WORD      16'h0000

// Controller map: bit 4 set selects the controller's own registers
`define HOST_ADDR_RESULT 5'h10
`define HOST_ADDR_STATUS 5'h11
`define HOST_SEL_BIT     4

`endif

// ---- oc_cpu_end.sv ----
`timescale 1ns/1ps
`include "oc_consts.svh"

module oc_cpu_end (
    io_bus_if.cpu           io,
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic [4:0] user_addr,
    input  wire logic [15:0] user_wdata,
    input  wire logic       user_wr,
    input  wire logic       user_rd,
    output logic [15:0]     user_rdata
);
    import oc_pkg::*;

    host_state_type state_q;
    logic [3:0]     addr_q;
    logic [7:0]     wdata_q;
    logic           wr_q;
    logic           rd_q;
    logic [7:0]     low_q;
    logic           wide_q;
    logic [15:0]    result_q;
    logic           own_w;
    logic           wide_w;
    logic           busy_w;

    assign own_w  = user_addr[`HOST_SEL_BIT];
    assign wide_w = (user_addr[3:0] == `OC_ADDR_CMPA_L) || (user_addr[3:0] == `OC_ADDR_CMPB_L);
    assign busy_w = (state_q != ST_IDLE);

    // Compare words go out high byte first, come back low byte first
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_q  <= ST_IDLE;
            addr_q   <= 4'h0;
            wdata_q  <= 8'h00;
            wr_q     <= 1'b0;
            rd_q     <= 1'b0;
            low_q    <= 8'h00;
            wide_q   <= 1'b0;
            result_q <= 16'h0000;
        end else begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (user_wr && !own_w) begin
                        wr_q <= 1'b1;
                        if (wide_w) begin
                            addr_q  <= user_addr[3:0] + 4'h1;
                            wdata_q <= user_wdata[15:8]; // R11
                            low_q   <= user_wdata[7:0];
                            state_q <= ST_WR_LOW;
                        end else begin
                            addr_q  <= user_addr[3:0];
                            wdata_q <= user_wdata[7:0]; // R04
                        end
                    end else if (user_rd && !own_w) begin
                        rd_q    <= 1'b1;
                        addr_q  <= user_addr[3:0];
                        wide_q  <= wide_w;
                        state_q <= ST_RD_ISSUE;
                    end
                end
                ST_WR_LOW: begin
                    wr_q    <= 1'b1;
                    addr_q  <= addr_q - 4'h1;
                    wdata_q <= low_q; // R11
                    state_q <= ST_IDLE;
                end
                ST_RD_ISSUE: begin
                    if (wide_q) begin
                        rd_q   <= 1'b1;
                        addr_q <= addr_q + 4'h1;
                    end
                    state_q <= ST_RD_LOW;
                end
                ST_RD_LOW: begin
                    result_q[7:0] <= io.io_rdata;
                    if (wide_q) begin
                        state_q <= ST_RD_HIGH;
                    end else begin
                        result_q[15:8] <= 8'h00;
                        state_q        <= ST_IDLE;
                    end
                end
                ST_RD_HIGH: begin
                    result_q[15:8] <= io.io_rdata;
                    state_q        <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    assign io.io_addr  = addr_q;
    assign io.io_wdata = wdata_q;
    assign io.io_wr    = wr_q;
    assign io.io_rd    = rd_q;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            user_rdata <= 16'h0000;
        end else if (user_rd) begin
            if (user_addr == `HOST_ADDR_RESULT) begin
                user_rdata <= result_q;
            end else begin
                user_rdata <= {15'h0000, busy_w};
            end
        end
    end
endmodule

// ---- oc_pkg.sv ----
package oc_pkg;

    typedef logic [1:0] action_type;
    typedef logic [3:0] mode_type;

    typedef enum logic [4:0] {
        ST_IDLE     = 5'b00001,
        ST_WR_LOW   = 5'b00010,
        ST_RD_ISSUE = 5'b00100,
        ST_RD_LOW   = 5'b01000,
        ST_RD_HIGH  = 5'b10000
    } host_state_type;

endpackage

// ---- oc_unit.sv ----
// How it works
// R01: Each channel compares counter with compare value
// R02: Match sets flag on following timer tick
// R03: Enabled flag requests irq; acknowledge clears it
// R04: Writing one clears a flag; zero leaves it
// R05: Output follows match, mode and action fields
// R06: Channel A compare value can define TOP
// R07: Buffering in twelve PWM modes, not others
// R08: Buffer loads active value at TOP/BOTTOM only
// R09: CPU reaches buffer or active by buffering
// R10: Only CPU writes change it; direct reads
// R11: High byte to temp, low write loads all
// R12: Force acts like match, no flag, non-PWM
// R13: Counter write blocks matches until next tick
// R14: Counter written to TOP misses that match
// R15: Software avoids writing BOTTOM while downcounting
// R16: Output state kept across mode changes
// R17: Action field takes effect immediately
// R18: Software sets output state before pin enable
// R19: Action zero leaves output state alone
// R20: Reset clears every output state to zero
`timescale 1ns/1ps
`include "oc_consts.svh"

module oc_unit #(
    parameter int CHANNELS = 2
) (
    io_bus_if.dev                io,
    input  wire logic            clock,
    input  wire logic            sys_rst,
    input  wire logic            timer_tick,
    input  wire logic [15:0]     counter_value,
    input  wire logic            counter_top,
    input  wire logic            counter_bottom,
    input  wire logic            count_up,
    input  wire logic            counter_written,
    input  wire logic [1:0]      irq_ack,
    output logic [1:0]           channel_output_state,
    output logic [1:0]           compare_irq,
    output logic                 top_from_compare_a,
    output logic [15:0]          compare_a_top
);
    import oc_pkg::*;

    mode_type       waveform_mode_sel_q;
    logic [3:0]     compare_output_action_q;
    logic [1:0]     compare_irq_enable_q;
    logic [7:0]     temp_q;
    logic           block_q;
    logic [7:0]     rdata_q;
    logic           pwm_w;
    logic           fast_w;
    logic           bottom_update_w;
    logic           update_point_w;
    logic           wr_w;
    logic [15:0]    active_w [CHANNELS];
    logic [15:0]    buffer_w [CHANNELS];
    logic [1:0]     flag_w;
    logic [1:0]     ostate_w;

    assign wr_w = io.io_wr;

    // Mode classes; reserved mode treated as non-PWM
    always_comb begin
        case (waveform_mode_sel_q)
            `OC_MODE_NORMAL, `OC_MODE_CTC_A, `OC_MODE_CTC_ICR, `OC_MODE_RESERVED: pwm_w = 1'b0;
            default: pwm_w = 1'b1; // R07
        endcase
    end

    always_comb begin
        case (waveform_mode_sel_q)
            4'h5, 4'h6, 4'h7, 4'hE, `OC_MODE_FAST_A: fast_w = 1'b1;
            default: fast_w = 1'b0;
        endcase
    end

    // Phase and frequency correct modes reload at BOTTOM, other PWM modes at TOP
    assign bottom_update_w = (waveform_mode_sel_q == `OC_MODE_PFC_ICR) || (waveform_mode_sel_q == `OC_MODE_PFC_A);
    assign update_point_w  = timer_tick && (bottom_update_w ? counter_bottom : counter_top); // R08

    // Next output state for an event
    function automatic logic wave_next(
        input logic       cur,
        input action_type act,
        input logic       is_match,
        input logic       is_bottom,
        input logic       toggle_ok
    );
        logic res;
        res = cur;
        if (act == `OC_ACT_NONE) begin
            res = cur; // R19
        end else if (!pwm_w) begin
            if (is_match) begin
                case (act)
                    `OC_ACT_TOGGLE: res = ~cur;
                    `OC_ACT_CLEAR:  res = 1'b0;
                    default:        res = 1'b1;
                endcase
            end
        end else if (act == `OC_ACT_TOGGLE) begin
            if (is_match && toggle_ok) begin
                res = ~cur;
            end
        end else if (fast_w) begin
            if (is_match) begin
                res = (act == `OC_ACT_SET);
            end else if (is_bottom) begin
                res = (act == `OC_ACT_CLEAR);
            end
        end else if (is_match) begin
            // Phase correct: polarity depends on count direction
            res = (act == `OC_ACT_SET) ? count_up : ~count_up;
        end
        return res;
    endfunction

    // Control registers
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            waveform_mode_sel_q     <= 4'h0;
            compare_output_action_q <= 4'h0;
            compare_irq_enable_q    <= 2'h0;
        end else if (wr_w) begin
            case (io.io_addr)
                `OC_ADDR_MODE:   waveform_mode_sel_q     <= io.io_wdata[3:0];
                `OC_ADDR_ACTION: compare_output_action_q <= io.io_wdata[3:0]; // R17
                `OC_ADDR_IRQ_EN: compare_irq_enable_q    <= io.io_wdata[1:0];
                default: ;
            endcase
        end
    end

    // Shared high-byte latch
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            temp_q <= `OC_RST_BYTE;
        end else if (wr_w && (io.io_addr == `OC_ADDR_CMPA_H || io.io_addr == `OC_ADDR_CMPB_H)) begin
            temp_q <= io.io_wdata; // R11
        end
    end

    // Held until a tick consumes it, so a stopped timer still blocks
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            block_q <= 1'b0;
        end else if (counter_written) begin
            block_q <= 1'b1; // R13 R14
        end else if (timer_tick) begin
            block_q <= 1'b0;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_chan
            localparam logic [3:0] ADDR_L = 4'(2 * ch);
            logic [15:0] active_q;
            logic [15:0] buffer_q;
            logic        flag_q;
            logic        ostate_q;
            logic        match_w;
            logic        low_wr_w;
            logic        force_w;
            logic        toggle_ok_w;
            action_type  act_w;

            assign match_w  = (counter_value == active_q); // R01
            assign low_wr_w = wr_w && (io.io_addr == ADDR_L);
            assign force_w  = wr_w && (io.io_addr == `OC_ADDR_FORCE) && io.io_wdata[ch] && !pwm_w;
            assign act_w    = compare_output_action_q[2*ch +: 2];
            assign toggle_ok_w = (ch == 0) && (waveform_mode_sel_q == `OC_MODE_FAST_A ||
                                 waveform_mode_sel_q == `OC_MODE_PFC_A || waveform_mode_sel_q == `OC_MODE_PC_A);

            always_ff @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    buffer_q <= `OC_RST_WORD;
                end else if (low_wr_w && pwm_w) begin
                    buffer_q <= {temp_q, io.io_wdata}; // R09 R11
                end
            end

            always_ff @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    active_q <= `OC_RST_WORD;
                end else if (low_wr_w && !pwm_w) begin
                    active_q <= {temp_q, io.io_wdata}; // R09 R10
                end else if (pwm_w && update_point_w) begin
                    active_q <= buffer_q; // R08
                end
            end

            // Set wins over both clears
            always_ff @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    flag_q <= 1'b0;
                end else if (timer_tick && match_w && !block_q) begin
                    flag_q <= 1'b1; // R02 R13
                end else if (irq_ack[ch]) begin
                    flag_q <= 1'b0; // R03
                end else if (wr_w && io.io_addr == `OC_ADDR_FLAGS && io.io_wdata[ch]) begin
                    flag_q <= 1'b0; // R04
                end
            end

            // Not touched by mode writes, so state survives mode changes
            always_ff @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    ostate_q <= 1'b0; // R20
                end else if (force_w) begin
                    ostate_q <= wave_next(ostate_q, act_w, 1'b1, 1'b0, 1'b0); // R12
                end else if (timer_tick) begin
                    ostate_q <= wave_next(ostate_q, act_w, match_w && !block_q, counter_bottom, toggle_ok_w); // R05 R16
                end
            end

            assign active_w[ch] = active_q;
            assign buffer_w[ch] = buffer_q;
            assign flag_w[ch]   = flag_q;
            assign ostate_w[ch] = ostate_q;
        end
    endgenerate

    // Read path, data valid the cycle after the strobe
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= `OC_RST_BYTE;
        end else if (io.io_rd) begin
            case (io.io_addr)
                `OC_ADDR_CMPA_L: rdata_q <= pwm_w ? buffer_w[0][7:0]  : active_w[0][7:0];  // R10
                `OC_ADDR_CMPA_H: rdata_q <= pwm_w ? buffer_w[0][15:8] : active_w[0][15:8]; // R10
                `OC_ADDR_CMPB_L: rdata_q <= pwm_w ? buffer_w[1][7:0]  : active_w[1][7:0];
                `OC_ADDR_CMPB_H: rdata_q <= pwm_w ? buffer_w[1][15:8] : active_w[1][15:8];
                `OC_ADDR_ACTION: rdata_q <= {4'h0, compare_output_action_q};
                `OC_ADDR_MODE:   rdata_q <= {4'h0, waveform_mode_sel_q};
                `OC_ADDR_IRQ_EN: rdata_q <= {6'h00, compare_irq_enable_q};
                `OC_ADDR_FLAGS:  rdata_q <= {6'h00, flag_w};
                default:         rdata_q <= `OC_RST_BYTE;
            endcase
        end
    end
    assign io.io_rdata = rdata_q;

    // Registered outputs, one cycle behind the state they show
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            compare_irq          <= 2'h0;
            channel_output_state <= 2'h0;
            top_from_compare_a   <= 1'b0;
            compare_a_top        <= `OC_RST_WORD;
        end else begin
            compare_irq          <= flag_w & compare_irq_enable_q & ~irq_ack; // R03
            channel_output_state <= ostate_w;
            top_from_compare_a   <= (waveform_mode_sel_q == `OC_MODE_CTC_A) || (waveform_mode_sel_q == `OC_MODE_PFC_A)
                                    || (waveform_mode_sel_q == `OC_MODE_PC_A) || (waveform_mode_sel_q == `OC_MODE_FAST_A); // R06
            compare_a_top        <= active_w[0]; // R06
        end
    end
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
`include "oc_consts.svh"

module tb_top;
    import oc_pkg::*;
    logic        clock;
    logic        sys_rst = 1'b1;
    logic        timer_tick = 1'b0;
    logic [15:0] counter_value = 16'h0000;
    logic        counter_top = 1'b0;
    logic        counter_bottom = 1'b0;
    logic        counter_written = 1'b0;
    logic [1:0]  irq_ack = 2'h0;
    logic [1:0]  channel_output_state;
    logic [1:0]  compare_irq;
    logic        top_from_compare_a;
    logic [15:0] compare_a_top;
    logic [4:0]  user_addr = 5'h00;
    logic [15:0] user_wdata = 16'h0000;
    logic        user_wr = 1'b0;
    logic        user_rd = 1'b0;
    logic        rd_mark = 1'b0;
    logic        rd_pend = 1'b0;
    logic [15:0] user_rdata;
    logic [16:0] exp_q[$];
    logic [16:0] ent;
    logic [31:0] seed;
    logic [15:0] va;
    logic [15:0] vb;
    logic        st;
    action_type  act;
    int          failures = 0;
    int          cmp_count = 0;

    io_bus_if bus ();
    oc_unit oc_unit_inst (.io(bus), .clock(clock), .sys_rst(sys_rst), .timer_tick(timer_tick),
        .counter_value(counter_value), .counter_top(counter_top), .counter_bottom(counter_bottom), .count_up(1'b1),
        .counter_written(counter_written), .irq_ack(irq_ack), .channel_output_state(channel_output_state),
        .compare_irq(compare_irq), .top_from_compare_a(top_from_compare_a), .compare_a_top(compare_a_top));
    oc_cpu_end oc_cpu_end_inst (.io(bus), .clock(clock), .sys_rst(sys_rst), .user_addr(user_addr),
        .user_wdata(user_wdata), .user_wr(user_wr), .user_rd(user_rd), .user_rdata(user_rdata));
    oc_bus_sva oc_bus_sva_inst (.clock(clock), .sys_rst(sys_rst), .io_addr(bus.io_addr), .io_wdata(bus.io_wdata),
        .io_wr(bus.io_wr), .io_rd(bus.io_rd), .io_rdata(bus.io_rdata));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Only host reads are queued; device reads answer with status
    always @(posedge clock) begin
        if (rd_pend) begin
            ent = exp_q.pop_front();
            check("user_rdata", ent[16] ? user_rdata : {8'h00, user_rdata[7:0]}, ent[15:0]);
        end
        rd_pend <= rd_mark;
    end

    task automatic strobe(input logic [4:0] a, input logic [15:0] d, input logic w, input logic mark);
        @(posedge clock);
        user_addr <= a;
        user_wdata <= d;
        user_wr <= w;
        user_rd <= ~w;
        rd_mark <= mark;
        @(posedge clock);
        user_wr <= 1'b0;
        user_rd <= 1'b0;
        rd_mark <= 1'b0;
        // Longer than the worst busy span of three cycles
        repeat (5) @(posedge clock);
        #1;
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        strobe(a, d, 1'b1, 1'b0);
    endtask

    task automatic rd(input logic [4:0] a, input logic word, input logic [15:0] e);
        strobe(a, 16'h0000, 1'b0, 1'b0);
        exp_q.push_back({word, e});
        strobe(`HOST_ADDR_RESULT, 16'h0000, 1'b0, 1'b1);
    endtask

    task automatic tick(input logic [15:0] v, input logic top, input logic blk);
        @(posedge clock);
        counter_value <= v;
        counter_written <= blk;
        @(posedge clock);
        counter_written <= 1'b0;
        timer_tick <= 1'b1;
        counter_top <= top;
        counter_bottom <= (v == 16'h0000);
        @(posedge clock);
        timer_tick <= 1'b0;
        counter_top <= 1'b0;
        counter_bottom <= 1'b0;
        counter_value <= ~v;
        repeat (3) @(posedge clock);
        #1;
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #(40 * 6000);
        failures++;
        conclude();
    end

    initial begin
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        check("state_reset", {14'h0000, channel_output_state}, 16'h0000);
        rd(`OC_ADDR_MODE, 1'b0, 16'h0000);
        seed = lfsr(32'h62D2);
        va = seed[15:0];
        vb = va ^ 16'h0F0F;
        wr(5'h00, va);
        wr(5'h02, vb);
        rd(5'h00, 1'b1, va);
        rd(5'h02, 1'b1, vb);
        check("cmp_a_active", compare_a_top, va);
        wr(`OC_ADDR_ACTION, {12'h000, `OC_ACT_SET, `OC_ACT_TOGGLE});
        wr(`OC_ADDR_IRQ_EN, 16'h0003);
        tick(va, 1'b0, 1'b0);
        check("irq_a", {14'h0000, compare_irq}, 16'h0001);
        check("toggle_a", {14'h0000, channel_output_state}, 16'h0001);
        rd(`OC_ADDR_FLAGS, 1'b0, 16'h0001);
        @(posedge clock);
        irq_ack <= 2'h1;
        @(posedge clock);
        irq_ack <= 2'h0;
        repeat (2) @(posedge clock);
        #1;
        check("irq_ack", {14'h0000, compare_irq}, 16'h0000);
        rd(`OC_ADDR_FLAGS, 1'b0, 16'h0000);
        tick(vb, 1'b0, 1'b0);
        check("set_b", {14'h0000, channel_output_state}, 16'h0003);
        wr(`OC_ADDR_FLAGS, 16'h0000);
        rd(`OC_ADDR_FLAGS, 1'b0, 16'h0002);
        wr(`OC_ADDR_FLAGS, 16'h0002);
        rd(`OC_ADDR_FLAGS, 1'b0, 16'h0000);
        tick(va, 1'b0, 1'b1);
        rd(`OC_ADDR_FLAGS, 1'b0, 16'h0000);
        check("blocked", {14'h0000, channel_output_state}, 16'h0003);
        st = 1'b1;
        // Order clear, set, none, toggle
        for (int k = 0; k < 4; k++) begin
            act = action_type'(k[1:0] ^ 2'h2);
            wr(`OC_ADDR_ACTION, {12'h000, `OC_ACT_SET, act});
            wr(`OC_ADDR_FORCE, 16'h0001);
            st = (act == `OC_ACT_CLEAR) ? 1'b0 : (act == `OC_ACT_SET) ? 1'b1 : (act == `OC_ACT_TOGGLE) ? ~st : st;
            check("force_a", {15'h0000, channel_output_state[0]}, {15'h0000, st});
        end
        rd(`OC_ADDR_FLAGS, 1'b0, 16'h0000);
        rd(`OC_ADDR_FORCE, 1'b0, 16'h0000);
        rd(5'h0F, 1'b0, 16'h0000);
        wr(`OC_ADDR_MODE, {12'h000, `OC_MODE_FAST_A});
        check("top_sel", {15'h0000, top_from_compare_a}, 16'h0001);
        check("kept_state", {15'h0000, channel_output_state[0]}, {15'h0000, st});
        wr(5'h00, vb);
        rd(5'h00, 1'b1, vb);
        check("buffered", compare_a_top, va);
        tick(16'h0000, 1'b0, 1'b0);
        check("no_early_load", compare_a_top, va);
        check("bottom_b", {15'h0000, channel_output_state[1]}, 16'h0000);
        tick(va, 1'b1, 1'b0);
        check("top_load", compare_a_top, vb);
        st = ~st;
        check("pwm_toggle", {15'h0000, channel_output_state[0]}, {15'h0000, st});
        wr(`OC_ADDR_FORCE, 16'h0001);
        check("force_pwm", {15'h0000, channel_output_state[0]}, {15'h0000, st});
        // Counter written equal to the variable TOP: the channel A match must be lost
        wr(`OC_ADDR_FLAGS, 16'h0003);
        tick(vb, 1'b1, 1'b1);
        rd(`OC_ADDR_FLAGS, 1'b0, 16'h0000);
        check("top_missed", {15'h0000, channel_output_state[0]}, {15'h0000, st});
        exp_q.push_back({1'b1, 16'h0000});
        strobe(`HOST_ADDR_STATUS, 16'h0000, 1'b0, 1'b1);
        conclude();
    end
endmodule
